// File: logic/icb_crc8.sv
// icb_crc8: running eight-bit packet checksum, one byte per strobe
// assumes: clear and update come from logic on the same clock
`timescale 1ns/1ps
module icb_crc8 (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic upd,
  input wire logic [7:0] din,
  output logic [7:0] crc
);
  import icb_pkg::*;
  logic [7:0] crc_ff, nxt_crc, step;
  // -------------------------------------------------------------
  // msb-first bitwise division, unrolled by the loop
  // -------------------------------------------------------------
  always_comb begin
    step = crc_ff ^ din;
    for (int i = 0; i < 8; i++) begin
      step = step[7] ? ((step << 1) ^ CRC_POLY) : (step << 1);
    end
    nxt_crc = crc_ff;
    if (clr) begin
      nxt_crc = CRC_INIT;
    end else if (upd) begin
      nxt_crc = step;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      crc_ff <= CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end
  assign crc = crc_ff;
endmodule // icb_crc8

// File: logic/icb_ctrl_bank.sv
// icb_ctrl_bank: primary control register of the two-wire controller
// assumes: avalon master with waitrequest, byte engine on same clock,
// open-drain lines resolved outside from the output enables
//
// Function
// - writing soft reset resets the peripheral except the avalon slave and the line watcher
// - soft reset clears a stuck busy indication
// - checksum request cleared on send, start, stop, off
// - lost arbitration invalidates pending checksum
// - position set: acknowledge governs next byte
// - position clear: acknowledge governs current byte
// - hardware clears position when module disabled
// - acknowledge enable answers bytes; cleared when off
// - stop cleared on stop, set on timeout
// - master stop after current byte or start
// - slave stop releases lines after byte
// - start cleared when sent or off
// - slave start request waits for free bus
// - stretch disable forbids holding clock low
// - general call acknowledges broadcast address zero
// - checksum enable runs the packet checksum
// - module enable activates the controller
// - transmit stretch holds clock until refilled
// - checksum polynomial x^8+x^2+x+1 over all bytes
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module icb_ctrl_bank (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [icb_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire icb_pkg::icb_evt_t evt,
  output icb_pkg::icb_ctl_t ctl,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import icb_pkg::*;

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic busy_ff, nxt_busy;
  logic ack_lat_ff, nxt_ack_lat;
  logic chk_lat_ff, nxt_chk_lat;
  logic gc_hit_ff, nxt_gc_hit;
  logic rel_ff, nxt_rel;
  logic hold_ff, nxt_hold;
  logic sda_drv_ff, nxt_sda_drv;
  logic blk_rst_n;
  logic req, commit, wr_ctrl;
  logic [15:0] lane_mask, wmask;
  logic scl_s, sda_s, start_det, stop_det;
  logic on, stretch_want, ack_go;
  logic crc_clr, crc_upd;
  logic [7:0] crc_val;
  logic [15:0] stat_word;

  // soft reset holds checksum, bus state and line drive in reset
  assign blk_rst_n = rst_n & ~ctrl_ff[SOFT_RESET_BIT_POS];
  assign on = ctrl_ff[ON_POS];

  // -------------------------------------------------------------
  // bus line watcher and checksum engine
  // -------------------------------------------------------------
  icb_pin_watch u_watch (
    .clock(clock),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // checksum restarts each frame and on lost arbitration
  assign crc_clr = ~on | start_det | evt.arb_lost;
  assign crc_upd = ctrl_ff[CALC_POS] &
                   (evt.addr_strobe | evt.data_strobe);

  icb_crc8 u_crc (
    .clock(clock),
    .rst_n(blk_rst_n),
    .clr(crc_clr),
    .upd(crc_upd),
    .din(evt.data),
    .crc(crc_val)
  );

  // -------------------------------------------------------------
  // avalon slave: one wait cycle, commit when waitrequest low
  // -------------------------------------------------------------
  assign req = avs_read | avs_write;
  assign commit = req & ack_ff;
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;
  assign wr_ctrl = commit & avs_write & (avs_address == CTRL_OFS);
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wmask = lane_mask & CTRL_WMASK;

  // status word shows the block's own state
  always_comb begin
    stat_word = 16'h0000;
    stat_word[ST_BUSY_POS] = busy_ff;
    stat_word[ST_MASTER_POS] = evt.master;
    stat_word[ST_REL_POS] = rel_ff;
    stat_word[ST_HOLD_POS] = hold_ff;
    stat_word[ST_CRC_LSB +: 8] = crc_val;
  end

  // answer and read data prepared in the first cycle
  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (avs_read & ~ack_ff) begin
      unique case (avs_address)
        CTRL_OFS: nxt_rdata = {16'h0000, ctrl_ff & CTRL_WMASK};
        STAT_OFS: nxt_rdata = {16'h0000, stat_word};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // -------------------------------------------------------------
  // control register: hardware clears, software write, hw sets
  // -------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    // hardware clears first so a software set in the same cycle wins
    if (evt.chk_sent | evt.start_sent | evt.stop_sent |
        evt.arb_lost) begin
      nxt_ctrl[CHK_POS] = 1'b0;
    end
    if (stop_det) begin
      nxt_ctrl[STOP_POS] = 1'b0;
    end
    if (evt.start_sent) begin
      nxt_ctrl[START_POS] = 1'b0;
    end
    if (wr_ctrl) begin
      nxt_ctrl = (nxt_ctrl & ~wmask) | (avs_writedata[15:0] & wmask);
    end
    // disabled module drops its start and checksum requests and acknowledge bits
    if (!nxt_ctrl[ON_POS]) begin
      nxt_ctrl[CHK_POS] = 1'b0;
      nxt_ctrl[APOS_POS] = 1'b0;
      nxt_ctrl[ACKEN_POS] = 1'b0;
      nxt_ctrl[START_POS] = 1'b0;
    end
    // timeout forces a stop request
    if (evt.timeout) begin
      nxt_ctrl[STOP_POS] = 1'b1;
    end
    // while soft reset stands only the reset bit survives
    if (ctrl_ff[SOFT_RESET_BIT_POS]) begin
      nxt_ctrl = {nxt_ctrl[SOFT_RESET_BIT_POS], 15'h0000};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // -------------------------------------------------------------
  // bus state: busy, ack and checksum position, general call
  // -------------------------------------------------------------
  always_comb begin
    nxt_busy = busy_ff;
    if (start_det) begin
      nxt_busy = 1'b1;
    end else if (stop_det) begin
      nxt_busy = 1'b0;
    end
    // acknowledge and checksum flag sampled as each byte begins
    nxt_ack_lat = ack_lat_ff;
    nxt_chk_lat = chk_lat_ff;
    if (evt.byte_begin) begin
      nxt_ack_lat = ctrl_ff[ACKEN_POS];
      nxt_chk_lat = ctrl_ff[CHK_POS];
    end
    nxt_gc_hit = gc_hit_ff;
    if (start_det) begin
      nxt_gc_hit = 1'b0;
    end else if (evt.addr_strobe) begin
      nxt_gc_hit = ctrl_ff[GC_POS] & (evt.data[7:1] == GC_ADDR);
    end
  end

  // soft reset clears a busy flag even with no stop seen
  always_ff @(posedge clock) begin
    if (!blk_rst_n) begin
      busy_ff <= 1'b0;
      ack_lat_ff <= 1'b0;
      chk_lat_ff <= 1'b0;
      gc_hit_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      ack_lat_ff <= nxt_ack_lat;
      chk_lat_ff <= nxt_chk_lat;
      gc_hit_ff <= nxt_gc_hit;
    end
  end

  // -------------------------------------------------------------
  // line drive: slave release, clock hold, acknowledge bit
  // -------------------------------------------------------------
  // hold wanted on address match or finished byte, not if disabled
  assign stretch_want = on & ~ctrl_ff[HOLD_POS] & ~evt.master &
                        ~rel_ff & (evt.addr_flag | evt.byte_finished |
                        (evt.tx_empty & evt.byte_finished));
  // address slot answers own or broadcast match, data slot the bit
  assign ack_go = evt.addr_ack ? (evt.own_match | gc_hit_ff) :
                  ctl.ack_this_byte;

  always_comb begin
    nxt_rel = rel_ff;
    if (start_det | ~on) begin
      nxt_rel = 1'b0;
    end else if (evt.byte_end & ~evt.master & ctrl_ff[STOP_POS]) begin
      nxt_rel = 1'b1;
    end
    // grab the line only once it is already low
    nxt_hold = 1'b0;
    if (stretch_want & (hold_ff | ~scl_s)) begin
      nxt_hold = 1'b1;
    end
    nxt_sda_drv = on & ~rel_ff & evt.ack_slot & ack_go;
  end

  always_ff @(posedge clock) begin
    if (!blk_rst_n) begin
      rel_ff <= 1'b0;
      hold_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
    end else begin
      rel_ff <= nxt_rel;
      hold_ff <= nxt_hold;
      sda_drv_ff <= nxt_sda_drv;
    end
  end

  // open drain: only ever pulls low
  assign scl_o = 1'b0;
  assign scl_oe = hold_ff;
  assign sda_o = 1'b0;
  assign sda_oe = sda_drv_ff;

  // -------------------------------------------------------------
  // controls to the byte engine
  // -------------------------------------------------------------
  always_comb begin
    ctl.on = on;
    ctl.periph_rst = ctrl_ff[SOFT_RESET_BIT_POS];
    // repeated start as master, else wait for an idle bus
    ctl.gen_start = on & ctrl_ff[START_POS] &
                    (evt.master | ~busy_ff);
    ctl.gen_stop = on & ctrl_ff[STOP_POS] & evt.master &
                   (evt.byte_end | evt.start_sent);
    ctl.release_lines = rel_ff;
    // position picks latched or live acknowledge and checksum flag
    ctl.ack_this_byte = ctrl_ff[APOS_POS] ? ack_lat_ff :
                        ctrl_ff[ACKEN_POS];
    ctl.chk_this_byte = ctrl_ff[APOS_POS] ? chk_lat_ff :
                        ctrl_ff[CHK_POS];
    ctl.gc_enable = ctrl_ff[GC_POS];
    ctl.calc_enable = ctrl_ff[CALC_POS];
    ctl.crc = crc_val;
  end

endmodule // icb_ctrl_bank

// File: logic/icb_pin_watch.sv
// icb_pin_watch: synchronises the bus lines, finds start and stop
// assumes: lines arrive asynchronously and are sampled by clock
`timescale 1ns/1ps
module icb_pin_watch (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_s,
  output logic sda_s,
  output logic start_det,
  output logic stop_det
);
  import icb_pkg::*;
  logic [1:0] meta_ff, nxt_meta;
  logic [1:0] sync_ff, nxt_sync;
  logic [1:0] prev_ff, nxt_prev;
  // -------------------------------------------------------------
  // two-stage synchroniser and one history stage
  // -------------------------------------------------------------
  always_comb begin
    nxt_meta = {scl_i, sda_i};
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
      prev_ff <= 2'h3;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end
  // data line edges while clock line high
  assign scl_s = sync_ff[1];
  assign sda_s = sync_ff[0];
  assign start_det = sync_ff[1] & prev_ff[1] & prev_ff[0] & ~sync_ff[0];
  assign stop_det = sync_ff[1] & prev_ff[1] & ~prev_ff[0] & sync_ff[0];
endmodule // icb_pin_watch

// File: logic/icb_pkg.sv
// icb_pkg: constants and carriers for the two-wire primary control bank
// assumes: 32-bit avalon register port, byte addressed, 40 MHz clock
package icb_pkg;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] CTRL_OFS = 6'h00; // primary control
  localparam logic [5:0] STAT_OFS = 6'h20; // block state readback
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h9FE1; // writable bits
  // control field positions
  localparam int SOFT_RESET_BIT_POS = 15;
  localparam int CHK_POS = 12;
  localparam int APOS_POS = 11;
  localparam int ACKEN_POS = 10;
  localparam int STOP_POS = 9;
  localparam int START_POS = 8;
  localparam int HOLD_POS = 7;
  localparam int GC_POS = 6;
  localparam int CALC_POS = 5;
  localparam int ON_POS = 0;
  // status field positions
  localparam int ST_BUSY_POS = 0;
  localparam int ST_MASTER_POS = 1;
  localparam int ST_REL_POS = 2;
  localparam int ST_HOLD_POS = 3;
  localparam int ST_CRC_LSB = 8;
  // -------------------------------------------------------------
  // checksum and address constants
  // -------------------------------------------------------------
  localparam logic [7:0] CRC_POLY = 8'h07; // x^8+x^2+x+1
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [6:0] GC_ADDR = 7'h00;
  // events reported by the byte engine
  typedef struct packed {
    logic master; // engine is bus master
    logic start_sent; // start condition went out
    logic stop_sent; // stop condition went out
    logic chk_sent; // checksum byte went out
    logic timeout; // clock-low timeout seen
    logic arb_lost; // arbitration lost
    logic byte_begin; // new byte enters shift register
    logic byte_end; // byte transfer ends
    logic addr_flag; // address matched flag
    logic byte_finished; // byte finished flag
    logic tx_empty; // transmit empty flag
    logic addr_strobe; // address byte complete
    logic data_strobe; // data byte complete
    logic [7:0] data; // byte for the strobes
    logic own_match; // own address matched
    logic ack_slot; // ninth clock of a received byte
    logic addr_ack; // that slot follows the address
  } icb_evt_t;
  // controls to the byte engine
  typedef struct packed {
    logic on;
    logic periph_rst;
    logic gen_start;
    logic gen_stop;
    logic release_lines;
    logic ack_this_byte;
    logic chk_this_byte;
    logic gc_enable;
    logic calc_enable;
    logic [7:0] crc;
  } icb_ctl_t;
endpackage

// File: test/i2c_primary_control_bank_tb.sv
// self-checking bench for the control bank
// assumes: bench acts as byte engine, peer model on the lines
`timescale 1ns/1ps
module i2c_primary_control_bank_tb;
  import icb_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_oe;
  logic sda_oe;
  logic scl_line;
  logic sda_line;
  icb_evt_t evt = '0;
  icb_ctl_t ctl;
  int n_errors = 0;
  int n_compared = 0;
  // ------------------------------------------
  // clock, design and peer
  // ------------------------------------------
  always #12.5 clock = ~clock;
  icb_ctrl_bank dut_u (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .evt(evt), .ctl(ctl), .scl_i(scl_line), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe));
  icb_bus_peer peer_u (.dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe),
    .scl_line(scl_line), .sda_line(sda_line));
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    // waitrequest and read data judged at the rising edge itself
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) n_errors++;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask
  // bitwise crc, generator 07 hex, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_regs();
    rd(CTRL_OFS, 32'h0000_0000);
    wr(CTRL_OFS, 16'h7FFF);
    rd(CTRL_OFS, 32'h0000_1FE1);
    chk({31'h0, ctl.gen_start}, 32'h1);
    wr(6'h10, 16'hFFFF);
    rd(6'h10, 32'h0000_0000);
    wr(STAT_OFS, 16'hFFFF);
    rd(STAT_OFS, 32'h0000_0000);
  endtask
  task automatic t_off();
    wr(CTRL_OFS, 16'h1FE0);
    rd(CTRL_OFS, 32'h0000_02E0);
  endtask
  task automatic t_start();
    wr(CTRL_OFS, 16'h1101);
    @(posedge clock);
    evt.start_sent <= 1'b1;
    @(posedge clock);
    evt.start_sent <= 1'b0;
    rd(CTRL_OFS, 32'h0000_0001);
  endtask
  task automatic t_tmo();
    @(posedge clock);
    evt.master <= 1'b1;
    evt.timeout <= 1'b1;
    @(posedge clock);
    evt.timeout <= 1'b0;
    evt.byte_end <= 1'b1;
    @(negedge clock);
    chk({31'h0, ctl.gen_stop}, 32'h1);
    @(posedge clock);
    evt.byte_end <= 1'b0;
    evt.master <= 1'b0;
    rd(CTRL_OFS, 32'h0000_0201);
    peer_u.frame_start();
    rd(STAT_OFS, 32'h0000_0001);
    peer_u.frame_stop();
    rd(CTRL_OFS, 32'h0000_0001);
  endtask
  task automatic t_soft_reset_bit();
    peer_u.frame_start();
    rd(STAT_OFS, 32'h0000_0001);
    wr(CTRL_OFS, 16'h8001);
    rd(CTRL_OFS, 32'h0000_8000);
    rd(STAT_OFS, 32'h0000_0000);
    wr(CTRL_OFS, 16'h0000);
    peer_u.frame_stop();
  endtask
  task automatic t_crc();
    logic [7:0] e;
    e = crc_step(crc_step(8'h00, 8'hA4), 8'h3C);
    wr(CTRL_OFS, 16'h1021);
    @(posedge clock);
    evt.addr_strobe <= 1'b1;
    evt.data <= 8'hA4;
    @(posedge clock);
    evt.addr_strobe <= 1'b0;
    evt.data_strobe <= 1'b1;
    evt.data <= 8'h3C;
    @(posedge clock);
    evt.data_strobe <= 1'b0;
    rd(STAT_OFS, {16'h0000, e, 8'h00});
    // lost arbitration drops checksum and its request
    @(posedge clock);
    evt.arb_lost <= 1'b1;
    @(posedge clock);
    evt.arb_lost <= 1'b0;
    rd(STAT_OFS, 32'h0000_0000);
    rd(CTRL_OFS, 32'h0000_0021);
  endtask
  // two-byte receive: position set, ack and checksum move a byte
  task automatic t_pos();
    wr(CTRL_OFS, 16'h0C01);
    @(posedge clock);
    evt.byte_begin <= 1'b1;
    @(posedge clock);
    evt.byte_begin <= 1'b0;
    wr(CTRL_OFS, 16'h1801);
    @(negedge clock);
    chk({30'h0, ctl.ack_this_byte, ctl.chk_this_byte}, 32'h2);
    @(posedge clock);
    evt.byte_begin <= 1'b1;
    @(posedge clock);
    evt.byte_begin <= 1'b0;
    @(negedge clock);
    chk({30'h0, ctl.ack_this_byte, ctl.chk_this_byte}, 32'h1);
    wr(CTRL_OFS, 16'h0401);
    @(negedge clock);
    chk({30'h0, ctl.ack_this_byte, ctl.chk_this_byte}, 32'h2);
  endtask
  // data ack on the line, slave start held off while bus busy
  task automatic t_ack();
    peer_u.frame_start();
    wr(CTRL_OFS, 16'h0501);
    @(posedge clock);
    evt.ack_slot <= 1'b1;
    repeat (2) @(posedge clock);
    chk({30'h0, ctl.gen_start, sda_oe}, 32'h1);
    wr(CTRL_OFS, 16'h0001);
    repeat (2) @(posedge clock);
    chk({31'h0, sda_oe}, 32'h0);
    evt.ack_slot <= 1'b0;
    peer_u.frame_stop();
  endtask
  // broadcast address acked, slave stop releases the lines
  task automatic t_gc();
    peer_u.frame_start();
    wr(CTRL_OFS, 16'h0241);
    @(posedge clock);
    evt.addr_strobe <= 1'b1;
    evt.data <= 8'h00;
    @(posedge clock);
    evt.addr_strobe <= 1'b0;
    evt.ack_slot <= 1'b1;
    evt.addr_ack <= 1'b1;
    repeat (2) @(posedge clock);
    chk({31'h0, sda_oe}, 32'h1);
    evt.ack_slot <= 1'b0;
    evt.addr_ack <= 1'b0;
    evt.byte_end <= 1'b1;
    @(posedge clock);
    evt.byte_end <= 1'b0;
    rd(STAT_OFS, 32'h0000_0005);
    chk({31'h0, ctl.release_lines}, 32'h1);
    peer_u.frame_stop();
  endtask
  task automatic t_stretch();
    wr(CTRL_OFS, 16'h0001);
    @(posedge clock);
    evt.byte_finished <= 1'b1;
    evt.tx_empty <= 1'b1;
    peer_u.frame_start();
    rd(STAT_OFS, 32'h0000_0009);
    wr(CTRL_OFS, 16'h0081);
    rd(STAT_OFS, 32'h0000_0001);
    @(posedge clock);
    evt.byte_finished <= 1'b0;
    evt.tx_empty <= 1'b0;
    peer_u.frame_stop();
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_off();
    t_start();
    t_tmo();
    t_soft_reset_bit();
    t_crc();
    t_stretch();
    t_pos();
    t_ack();
    t_gc();
    wrap_up();
  end
  // watchdog against a hung handshake
  initial begin
    #1000000;
    n_errors++;
    wrap_up();
  end
endmodule // i2c_primary_control_bank_tb

// File: test/icb_bus_peer.sv
// remote bus party: pulls the two lines, idles them high
// assumes: design output enables pull low, lines have pull-ups
`timescale 1ns/1ps
module icb_bus_peer (
  input wire logic dut_scl_oe,
  input wire logic dut_sda_oe,
  output logic scl_line,
  output logic sda_line
);
  logic pull_scl = 1'b0;
  logic pull_sda = 1'b0;
  // ------------------------------------------
  // wired lines
  // ------------------------------------------
  // released line rises to the pull-up level
  assign scl_line = ~(dut_scl_oe | pull_scl);
  assign sda_line = ~(dut_sda_oe | pull_sda);
  // start: data falls with clock high, clock then held low
  task automatic frame_start();
    #5 pull_sda = 1'b1;
    #100 pull_scl = 1'b1;
    #100;
  endtask
  // stop: data rises with clock high, bus left released and idle
  task automatic frame_stop();
    #5 pull_sda = 1'b1;
    #100 pull_scl = 1'b0;
    #100 pull_sda = 1'b0;
    #100;
  endtask
endmodule // icb_bus_peer

// File: test/icb_ctrl_bank_properties.sv
// checker for the control bank ports, bound below
// assumes: one clock domain, synchronous active-low reset
`timescale 1ns/1ps
module icb_ctrl_bank_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [icb_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire icb_pkg::icb_evt_t evt,
  input wire icb_pkg::icb_ctl_t ctl,
  input wire logic scl_oe
);
  import icb_pkg::*;
  // ------------------------------------------
  // properties
  // ------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic rd_c;
  logic wr_c;
  // commit cycles of reads and writes
  assign rd_c = avs_read & ~avs_waitrequest;
  assign wr_c = avs_write & ~avs_waitrequest;
  property p_wait;
    $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait cycle wrong");
  property p_resv;
    rd_c && avs_address == CTRL_OFS |-> avs_readdata[31:16] == 16'h0000
      && avs_readdata[14:13] == 2'h0 && avs_readdata[4:1] == 4'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_unmap;
    rd_c && avs_address != CTRL_OFS && avs_address != STAT_OFS
      |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped nonzero");
  property p_soft_reset_bit;
    ctl.periph_rst [*2] |-> !ctl.on && ctl.crc == 8'h00 && !scl_oe;
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset leak");
  property p_off_start;
    !ctl.on && !wr_c |=> !ctl.gen_start;
  endproperty
  a_off_start: assert property (p_off_start) else $error("start when off");
  property p_start_clr;
    evt.start_sent && !wr_c |=> !ctl.gen_start;
  endproperty
  a_start_clr: assert property (p_start_clr) else $error("start kept");
  property p_tmo;
    evt.timeout && ctl.on && !ctl.periph_rst ##1 evt.byte_end && evt.master
      |-> ctl.gen_stop;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout no stop");
  property p_stop_src;
    ctl.gen_stop |-> evt.master && (evt.byte_end || evt.start_sent);
  endproperty
  a_stop_src: assert property (p_stop_src) else $error("stray stop");
  property p_hold_slave;
    $rose(scl_oe) |-> !$past(evt.master);
  endproperty
  a_hold_slave: assert property (p_hold_slave) else $error("master hold");
  property p_crc_off;
    !ctl.on [*2] |-> ctl.crc == 8'h00;
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("crc kept");
  // main scenarios seen
  c_write: cover property (wr_c);
  c_stop: cover property (ctl.gen_stop);
  c_hold: cover property (scl_oe);
endmodule // icb_ctrl_bank_props

bind icb_ctrl_bank icb_ctrl_bank_props chk_u (.clock, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .evt, .ctl,
  .scl_oe);
